// ---- hw/ive_top.sv ----
// Interrupt controller top: masking, arbitration and vector hand-off.
// Assumes peripherals own their pending flags and the core acks each call.
// How it works
// (RQ1) Eighteen sources vector from 0x0003 to 0x008B eight bytes apart in order 0..17, reset at 0x0000.
// (RQ2) With the global bit 7 set, each source requests only when its own mask bit allows it.
// (RQ3) With the global bit clear, no source requests at all.
// (RQ4) Bit 6 gates every serial peripheral flag.
// (RQ5) Bit 5 gates timer 2, where either its low or high overflow flag requests.
// (RQ6) Bit 4 gates the UART receive and transmit flags.
// (RQ7) Bit 3 gates the timer 1 overflow flag.
// (RQ8) Bit 2 gates external input line 1.
// (RQ9) Bit 1 gates the timer 0 overflow flag.
// (RQ10) Bit 0 gates external input line 0.
// (RQ11) The enable register sits at 0xA8 on every page, is bit and byte writable, and resets to zero.
// (RQ12) On vectoring, the external inputs, timer 0/1 and network flags get a clear pulse; others stay.
// (RQ13) Each source is low or high level, high preempts a low routine, equals resolve by fixed order.
// (RQ14) Requests are sampled and decoded every cycle, one cycle to detect, the core's call takes four more.
// (RQ15) Flags are set by their sources regardless of enable; a request needs flag and enable.
// (RQ16) The winning vector goes out with a strobe; equal or lower levels wait for the return.
// (RQ17) Sources without a layout here come in as single flags with their own enable and priority bits.
`timescale 1ns/1ps
`default_nettype none
module ive_top (
    input  wire logic                             CORE_CLK,
    input  wire logic                             RST_N,
    input  wire logic [7:0]                       SFR_ADDR,
    input  wire logic                             SFR_WR,
    input  wire logic [7:0]                       SFR_WDATA,
    input  wire logic                             SFR_BIT_WR,
    input  wire logic [2:0]                       SFR_BIT_SEL,
    input  wire logic                             SFR_BIT_VAL,
    input  wire logic                             SFR_RD,
    output logic      [7:0]                       SFR_RDATA,
    output logic                                  SFR_RD_HIT,
    input  wire logic                             EXT_INPUT_ZERO_FLAG,
    input  wire logic                             TIMER0_OVERFLOW_FLAG,
    input  wire logic                             EXT_INPUT_ONE_FLAG,
    input  wire logic                             TIMER1_OVERFLOW_FLAG,
    input  wire logic                             UART_RX_FLAG,
    input  wire logic                             UART_TX_FLAG,
    input  wire logic                             TIMER2_LOW_OVERFLOW_FLAG,
    input  wire logic                             TIMER2_HIGH_OVERFLOW_FLAG,
    input  wire logic [3:0]                       SPI_FLAGS,
    input  wire logic [ive_pkg::NUM_EXT_SRC-1:0]  EXT_SRC_FLAGS,
    input  wire logic [ive_pkg::NUM_EXT_SRC-1:0]  EXT_SRC_ENABLE,
    input  wire logic [ive_pkg::NUM_SRC-1:0]      SRC_PRIORITY,
    input  wire logic                             IRQ_ACK,
    input  wire logic                             IRQ_RETURN,
    output logic                                  IRQ_REQ,
    output logic      [15:0]                      IRQ_VECTOR,
    output logic                                  IRQ_LEVEL,
    output logic      [ive_pkg::NUM_SRC-1:0]      FLAG_CLEAR
);

    // ************************************************************
    // Enable register
    // ************************************************************
    logic [7:0] ie;

    ive_enable_reg u_ie (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .addr    (SFR_ADDR),
        .wr      (SFR_WR),
        .wdata   (SFR_WDATA),
        .bit_wr  (SFR_BIT_WR),
        .bit_sel (SFR_BIT_SEL),
        .bit_val (SFR_BIT_VAL),
        .rd      (SFR_RD),
        .enable  (ie),
        .rdata   (SFR_RDATA),
        .rd_hit  (SFR_RD_HIT)
    );

    // ************************************************************
    // Pending and enable vectors
    // ************************************************************
    logic [ive_pkg::NUM_SRC-1:0] pend;
    logic [ive_pkg::NUM_SRC-1:0] en;
    logic [ive_pkg::NUM_SRC-1:0] lvl_ok;
    logic                        act_low_ff;
    logic                        act_high_ff;

    always_comb begin
        // Flags arrive already set by their sources whatever the mask [RQ15]
        pend = '0;
        pend[ive_pkg::SRC_EXT0] = EXT_INPUT_ZERO_FLAG;
        pend[ive_pkg::SRC_TMR0] = TIMER0_OVERFLOW_FLAG;
        pend[ive_pkg::SRC_EXT1] = EXT_INPUT_ONE_FLAG;
        pend[ive_pkg::SRC_TMR1] = TIMER1_OVERFLOW_FLAG;
        pend[ive_pkg::SRC_UART] = UART_RX_FLAG | UART_TX_FLAG;                       // [RQ6]
        pend[ive_pkg::SRC_TMR2] = TIMER2_LOW_OVERFLOW_FLAG | TIMER2_HIGH_OVERFLOW_FLAG; // [RQ5]
        pend[ive_pkg::SRC_SPI]  = |SPI_FLAGS;                                        // [RQ4]
        pend[ive_pkg::NUM_SRC-1:ive_pkg::FIRST_EXT_SRC] = EXT_SRC_FLAGS;             // [RQ17]

        en = '0;
        en[ive_pkg::SRC_EXT0] = ie[ive_pkg::IE_EXT0_BIT]; // [RQ10]
        en[ive_pkg::SRC_TMR0] = ie[ive_pkg::IE_TMR0_BIT]; // [RQ9]
        en[ive_pkg::SRC_EXT1] = ie[ive_pkg::IE_EXT1_BIT]; // [RQ8]
        en[ive_pkg::SRC_TMR1] = ie[ive_pkg::IE_TMR1_BIT]; // [RQ7]
        en[ive_pkg::SRC_UART] = ie[ive_pkg::IE_UART_BIT]; // [RQ6]
        en[ive_pkg::SRC_TMR2] = ie[ive_pkg::IE_TMR2_BIT]; // [RQ5]
        en[ive_pkg::SRC_SPI]  = ie[ive_pkg::IE_SPI_BIT];  // [RQ4]
        en[ive_pkg::NUM_SRC-1:ive_pkg::FIRST_EXT_SRC] = EXT_SRC_ENABLE; // [RQ17]

        // A high routine blocks all; a low routine lets only high through [RQ13] [RQ16]
        for (int i = 0; i < ive_pkg::NUM_SRC; i++) begin
            lvl_ok[i] = !act_high_ff && (!act_low_ff || SRC_PRIORITY[i]);
        end
    end

    // ************************************************************
    // Arbitration
    // ************************************************************
    ive_arb_if arb_bus ();

    // Global bit overrides every individual mask [RQ2] [RQ3] [RQ15]
    assign arb_bus.elig = pend & en & lvl_ok & {ive_pkg::NUM_SRC{ie[ive_pkg::IE_GLOBAL_BIT]}};
    assign arb_bus.prio = SRC_PRIORITY; // [RQ17]

    ive_arbiter u_arb (
        .a (arb_bus)
    );

    // ************************************************************
    // Request strobe and vector
    // ************************************************************
    logic                        req_ff;
    logic                        nxt_req;
    logic [15:0]                 vec_ff;
    logic [15:0]                 nxt_vec;
    logic                        lvl_ff;
    logic                        nxt_lvl;
    logic [ive_pkg::IDX_W-1:0]   idx_ff;
    logic [ive_pkg::IDX_W-1:0]   nxt_idx;
    logic [ive_pkg::NUM_SRC-1:0] clr_ff;
    logic [ive_pkg::NUM_SRC-1:0] nxt_clr;
    logic                        taken;

    always_comb begin
        taken   = req_ff && IRQ_ACK;
        nxt_req = req_ff;
        nxt_vec = vec_ff;
        nxt_lvl = lvl_ff;
        nxt_idx = idx_ff;
        nxt_clr = '0;
        if (taken) begin
            // Hold the vector the core just took; drop the strobe
            nxt_req = 1'b0;
            // Only the self-clearing sources get a pulse [RQ12]
            nxt_clr[idx_ff] = ive_pkg::HW_CLEAR_MASK[idx_ff];
        end else begin
            // Re-decoded every cycle, so a newer winner replaces an unacked one [RQ14]
            nxt_req = arb_bus.hit; // [RQ16]
            if (arb_bus.hit) begin
                nxt_vec = ive_pkg::vector_of(arb_bus.idx); // [RQ1]
                nxt_lvl = arb_bus.level;
                nxt_idx = arb_bus.idx;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            req_ff <= 1'b0;
            vec_ff <= ive_pkg::RESET_VECTOR; // [RQ1]
            lvl_ff <= 1'b0;
            idx_ff <= '0;
            clr_ff <= '0;
        end else begin
            req_ff <= nxt_req;
            vec_ff <= nxt_vec;
            lvl_ff <= nxt_lvl;
            idx_ff <= nxt_idx;
            clr_ff <= nxt_clr;
        end
    end

    // ************************************************************
    // Routines in service
    // ************************************************************
    logic nxt_act_low;
    logic nxt_act_high;

    always_comb begin
        nxt_act_low  = act_low_ff;
        nxt_act_high = act_high_ff;
        // Return ends the innermost routine; high is always the inner one
        if (IRQ_RETURN) begin
            if (act_high_ff) begin
                nxt_act_high = 1'b0; // [RQ16]
            end else begin
                nxt_act_low = 1'b0;  // [RQ16]
            end
        end
        if (taken) begin
            if (lvl_ff) begin
                nxt_act_high = 1'b1; // [RQ13]
            end else begin
                nxt_act_low = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            act_low_ff  <= 1'b0;
            act_high_ff <= 1'b0;
        end else begin
            act_low_ff  <= nxt_act_low;
            act_high_ff <= nxt_act_high;
        end
    end

    assign IRQ_REQ    = req_ff;
    assign IRQ_VECTOR = vec_ff;
    assign IRQ_LEVEL  = lvl_ff;
    assign FLAG_CLEAR = clr_ff;

endmodule // ive_top
`default_nettype wire

// ---- hw/ive_pkg.sv ----
// Shared constants for the interrupt vector and enable block.
// Assumes a single core clock; flag sources live in the peripherals.
package ive_pkg;

    // ************************************************************
    // Sources and vectors
    // ************************************************************
    localparam int          NUM_SRC        = 18;
    localparam int          IDX_W          = 5;
    localparam int          NUM_EXT_SRC    = 11;
    localparam int          FIRST_EXT_SRC  = 7;
    localparam logic [15:0] RESET_VECTOR   = 16'h0000;
    localparam logic [15:0] VECTOR_BASE    = 16'h0003;
    localparam logic [15:0] VECTOR_LAST    = 16'h008B;
    localparam logic [15:0] VECTOR_STEP    = 16'h0008;
    // External inputs 0/1, timer 0/1 overflows and the network controller
    localparam logic [17:0] HW_CLEAR_MASK  = 18'h1000F;

    // Source indices in fixed priority order
    localparam int SRC_EXT0   = 0;
    localparam int SRC_TMR0   = 1;
    localparam int SRC_EXT1   = 2;
    localparam int SRC_TMR1   = 3;
    localparam int SRC_UART   = 4;
    localparam int SRC_TMR2   = 5;
    localparam int SRC_SPI    = 6;

    // ************************************************************
    // Enable register
    // ************************************************************
    localparam logic [7:0] IE_ADDR        = 8'hA8;
    localparam logic [7:0] IE_RESET       = 8'h00;
    localparam int         IE_EXT0_BIT    = 0;
    localparam int         IE_TMR0_BIT    = 1;
    localparam int         IE_EXT1_BIT    = 2;
    localparam int         IE_TMR1_BIT    = 3;
    localparam int         IE_UART_BIT    = 4;
    localparam int         IE_TMR2_BIT    = 5;
    localparam int         IE_SPI_BIT     = 6;
    localparam int         IE_GLOBAL_BIT  = 7;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES   = 4;
    localparam int FASTEST_RESPONSE_CYCLES = DETECT_CYCLES + CALL_CYCLES;

    function automatic logic [15:0] vector_of(input logic [IDX_W-1:0] idx);
        vector_of = VECTOR_BASE + {8'h00, idx, 3'b000};
    endfunction

endpackage

// ---- hw/ive_arb_if.sv ----
// Carries eligible requests into the arbiter and the winner back out.
// Assumes both ends sit on the same core clock.
`timescale 1ns/1ps
`default_nettype none
interface ive_arb_if;
    logic [ive_pkg::NUM_SRC-1:0] elig;
    logic [ive_pkg::NUM_SRC-1:0] prio;
    logic                        hit;
    logic [ive_pkg::IDX_W-1:0]   idx;
    logic                        level;

    modport arb  (input elig, input prio, output hit, output idx, output level);
    modport user (output elig, output prio, input hit, input idx, input level);
endinterface
`default_nettype wire

// ---- hw/ive_arbiter.sv ----
// Two-level priority decode with fixed order among equals.
// Assumes elig is already masked; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module ive_arbiter (
    ive_arb_if.arb a
);

    // ************************************************************
    // Decode
    // ************************************************************
    always_comb begin
        a.hit   = 1'b0;
        a.idx   = '0;
        a.level = 1'b0;
        // High level first, lowest index wins within a level [RQ13]
        for (int i = ive_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (a.elig[i] && !a.prio[i]) begin
                a.hit   = 1'b1;
                a.idx   = i[ive_pkg::IDX_W-1:0];
                a.level = 1'b0;
            end
        end
        for (int i = ive_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (a.elig[i] && a.prio[i]) begin
                a.hit   = 1'b1;
                a.idx   = i[ive_pkg::IDX_W-1:0];
                a.level = 1'b1;
            end
        end
    end

endmodule // ive_arbiter
`default_nettype wire

// ---- hw/ive_enable_reg.sv ----
// Interrupt enable register on the special-function bus.
// Assumes one access per cycle; decoded without any page select.
`timescale 1ns/1ps
`default_nettype none
module ive_enable_reg (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] addr,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic       bit_wr,
    input  wire logic [2:0] bit_sel,
    input  wire logic       bit_val,
    input  wire logic       rd,
    output logic      [7:0] enable,
    output logic      [7:0] rdata,
    output logic            rd_hit
);

    logic [7:0] ie_ff;
    logic [7:0] nxt_ie;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       hit_ff;
    logic       nxt_hit;
    logic       sel;

    // ************************************************************
    // Access
    // ************************************************************
    always_comb begin
        // Same address from every page, so no page input is looked at [RQ11]
        sel       = (addr == ive_pkg::IE_ADDR);
        nxt_ie    = ie_ff;
        nxt_rdata = 8'h00;
        nxt_hit   = 1'b0;
        if (sel && wr) begin
            nxt_ie = wdata; // [RQ11]
        end else if (sel && bit_wr) begin
            nxt_ie[bit_sel] = bit_val; // [RQ11]
        end
        if (sel && rd) begin
            nxt_rdata = ie_ff;
            nxt_hit   = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_ff    <= ive_pkg::IE_RESET; // [RQ11]
            rdata_ff <= 8'h00;
            hit_ff   <= 1'b0;
        end else begin
            ie_ff    <= nxt_ie;
            rdata_ff <= nxt_rdata;
            hit_ff   <= nxt_hit;
        end
    end

    assign enable = ie_ff;
    assign rdata  = rdata_ff;
    assign rd_hit = hit_ff;

endmodule // ive_enable_reg
`default_nettype wire

// ---- tb/ive_top_assertions.sv ----
// Port checker for ive_top: gating, vectors, clears, reads.
// Assumes a bind onto ive_top; mirrors the enable register.
`timescale 1ns/1ps
`default_nettype none
module ive_top_assertions (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic [7:0]  SFR_ADDR,
    input wire logic        SFR_WR,
    input wire logic [7:0]  SFR_WDATA,
    input wire logic        SFR_BIT_WR,
    input wire logic [2:0]  SFR_BIT_SEL,
    input wire logic        SFR_BIT_VAL,
    input wire logic        SFR_RD,
    input wire logic [7:0]  SFR_RDATA,
    input wire logic        SFR_RD_HIT,
    input wire logic        EXT_INPUT_ZERO_FLAG,
    input wire logic        TIMER0_OVERFLOW_FLAG,
    input wire logic        EXT_INPUT_ONE_FLAG,
    input wire logic        TIMER1_OVERFLOW_FLAG,
    input wire logic        UART_RX_FLAG,
    input wire logic        UART_TX_FLAG,
    input wire logic        TIMER2_LOW_OVERFLOW_FLAG,
    input wire logic        TIMER2_HIGH_OVERFLOW_FLAG,
    input wire logic [3:0]  SPI_FLAGS,
    input wire logic [10:0] EXT_SRC_FLAGS,
    input wire logic [10:0] EXT_SRC_ENABLE,
    input wire logic [17:0] SRC_PRIORITY,
    input wire logic        IRQ_ACK,
    input wire logic        IRQ_REQ,
    input wire logic [15:0] IRQ_VECTOR,
    input wire logic        IRQ_LEVEL,
    input wire logic [17:0] FLAG_CLEAR
);
    // ********************************
    // Helper state
    // ********************************
    // Copies lag one edge so they line up with the registered request
    logic [7:0]  en_ff, nxt_en;
    logic [17:0] raw, raw_ff, gate_ff, pri_ff;
    logic        glob_ff;
    logic [4:0]  vidx;
    logic        hit;
    assign hit  = SFR_ADDR == ive_pkg::IE_ADDR;
    assign vidx = 5'((IRQ_VECTOR - ive_pkg::VECTOR_BASE) >> 3);
    assign raw  = {EXT_SRC_FLAGS, |SPI_FLAGS, TIMER2_LOW_OVERFLOW_FLAG | TIMER2_HIGH_OVERFLOW_FLAG,
                   UART_RX_FLAG | UART_TX_FLAG, TIMER1_OVERFLOW_FLAG, EXT_INPUT_ONE_FLAG,
                   TIMER0_OVERFLOW_FLAG, EXT_INPUT_ZERO_FLAG};
    always_comb begin
        nxt_en = en_ff;
        if (SFR_WR && hit) nxt_en = SFR_WDATA;
        else if (SFR_BIT_WR && hit) nxt_en[SFR_BIT_SEL] = SFR_BIT_VAL;
    end
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            en_ff <= 8'h00; raw_ff <= 18'h00000; gate_ff <= 18'h00000; pri_ff <= 18'h00000; glob_ff <= 1'b0;
        end else begin
            en_ff <= nxt_en; raw_ff <= raw; gate_ff <= {EXT_SRC_ENABLE, en_ff[6:0]};
            pri_ff <= SRC_PRIORITY; glob_ff <= en_ff[7];
        end
    end
    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    vector_grid_a: assert property (IRQ_REQ |-> IRQ_VECTOR <= 16'h008B && IRQ_VECTOR[2:0] == 3'h3)
        else $error("vector off grid");
    global_gate_a: assert property (IRQ_REQ |-> glob_ff)
        else $error("request with global enable off");
    mask_gate_a: assert property (IRQ_REQ |-> gate_ff[vidx])
        else $error("request from masked source");
    flag_gate_a: assert property (IRQ_REQ |-> raw_ff[vidx])
        else $error("request without pending flag");
    level_match_a: assert property (IRQ_REQ |-> IRQ_LEVEL == pri_ff[vidx])
        else $error("level does not match source");
    ack_drop_a: assert property (IRQ_REQ && IRQ_ACK |=> !IRQ_REQ)
        else $error("request held after ack");
    auto_clear_a: assert property (IRQ_REQ && IRQ_ACK |=>
        FLAG_CLEAR == (ive_pkg::HW_CLEAR_MASK & (18'h00001 << $past(vidx))))
        else $error("wrong clear pulse");
    clear_quiet_a: assert property (!(IRQ_REQ && IRQ_ACK) |=> FLAG_CLEAR == 18'h00000)
        else $error("clear pulse without ack");
    read_answer_a: assert property (SFR_RD && hit |=> SFR_RD_HIT && SFR_RDATA == $past(en_ff))
        else $error("enable read wrong");
    read_miss_a: assert property (!(SFR_RD && hit) |=> !SFR_RD_HIT && SFR_RDATA == 8'h00)
        else $error("read answer without read");
    ack_c: cover property (IRQ_REQ && IRQ_ACK);
    high_c: cover property (IRQ_REQ && IRQ_LEVEL);
    read_c: cover property (SFR_RD_HIT);
endmodule // ive_top_assertions
bind ive_top ive_top_assertions i_ive_top_assertions (.*);
`default_nettype wire

// ---- tb/ive_core_model.sv ----
// Core side of the vector hand-off: acks requests, signals returns.
// Assumes the bench steers take, ack_wait and ret_cmd.
`timescale 1ns/1ps
`default_nettype none
module ive_core_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        irq_req,
    input  wire logic [15:0] irq_vector,
    input  wire logic        take,
    input  wire logic [3:0]  ack_wait,
    input  wire logic        ret_cmd,
    output logic             irq_ack,
    output logic             irq_return,
    output logic      [15:0] taken_vec
);
    logic [3:0] cnt;
    // Slow acks stress a request that must stand until taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_ack <= 1'b0; irq_return <= 1'b0; cnt <= 4'h0; taken_vec <= 16'h0000;
        end else begin
            irq_ack    <= 1'b0;
            irq_return <= ret_cmd;
            // Vector is taken at the edge that sees the ack, since an unacked winner may still be replaced
            if (irq_ack && irq_req) taken_vec <= irq_vector;
            if (take && irq_req && !irq_ack) begin
                if (cnt == ack_wait) begin
                    irq_ack   <= 1'b1;
                    cnt       <= 4'h0;
                end else cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // ive_core_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench for ive_top: register access, masking per source, priority.
// Assumes the core model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        core_clk, rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, sfr_rd_hit;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, flg;
    logic [2:0]  sfr_bit_sel;
    logic [3:0]  spi_flg, ack_wait;
    logic [10:0] ext_flg, ext_en;
    logic [17:0] prio, flag_clear;
    logic        irq_ack, irq_ret, irq_req, irq_level, take, ret_cmd;
    logic [15:0] irq_vector, taken_vec;
    int          num_errors, n_checks, n, s;
    ive_top i_ive_top (.CORE_CLK(core_clk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr),
        .SFR_WDATA(sfr_wdata), .SFR_BIT_WR(sfr_bit_wr), .SFR_BIT_SEL(sfr_bit_sel), .SFR_BIT_VAL(sfr_bit_val),
        .SFR_RD(sfr_rd), .SFR_RDATA(sfr_rdata), .SFR_RD_HIT(sfr_rd_hit), .EXT_INPUT_ZERO_FLAG(flg[0]),
        .TIMER0_OVERFLOW_FLAG(flg[1]), .EXT_INPUT_ONE_FLAG(flg[2]), .TIMER1_OVERFLOW_FLAG(flg[3]),
        .UART_RX_FLAG(flg[4]), .UART_TX_FLAG(flg[5]), .TIMER2_LOW_OVERFLOW_FLAG(flg[6]),
        .TIMER2_HIGH_OVERFLOW_FLAG(flg[7]), .SPI_FLAGS(spi_flg), .EXT_SRC_FLAGS(ext_flg),
        .EXT_SRC_ENABLE(ext_en), .SRC_PRIORITY(prio), .IRQ_ACK(irq_ack), .IRQ_RETURN(irq_ret),
        .IRQ_REQ(irq_req), .IRQ_VECTOR(irq_vector), .IRQ_LEVEL(irq_level), .FLAG_CLEAR(flag_clear));
    ive_core_model i_ive_core_model (.clk(core_clk), .rst_n(rst_n), .irq_req(irq_req),
        .irq_vector(irq_vector), .take(take), .ack_wait(ack_wait), .ret_cmd(ret_cmd),
        .irq_ack(irq_ack), .irq_return(irq_ret), .taken_vec(taken_vec));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // ********************************
    // Tasks
    // ********************************
    task automatic check(input string nm, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk); sfr_addr = a; sfr_wdata = d; sfr_wr = 1'b1;
        @(negedge core_clk); sfr_wr = 1'b0;
    endtask
    task automatic sfr_bit(input logic [2:0] b, input logic v);
        @(negedge core_clk); sfr_addr = ive_pkg::IE_ADDR; sfr_bit_sel = b; sfr_bit_val = v; sfr_bit_wr = 1'b1;
        @(negedge core_clk); sfr_bit_wr = 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] d, input logic h);
        @(negedge core_clk); sfr_addr = a; sfr_rd = 1'b1;
        @(negedge core_clk); sfr_rd = 1'b0;
        check("rdata", 18'(d), 18'(sfr_rdata));
        check("rd_hit", 18'(h), 18'(sfr_rd_hit));
    endtask
    task automatic wait_req;
        n = 0;
        while (irq_req !== 1'b1 && n < 20) begin @(negedge core_clk); n++; end
        if (irq_req !== 1'b1) begin num_errors++; wrap_up(); end
    endtask
    task automatic quiet(input int c);
        repeat (c) @(negedge core_clk);
        check("irq_req", 18'h00000, 18'(irq_req));
    endtask
    task automatic raise(input int j, input logic v);
        if (j < 8) flg[j] = v;
        else if (j < 10) spi_flg[(j - 8) * 3] = v;
        else ext_flg[j - 1] = v;
    endtask
    task automatic give_return;
        @(negedge core_clk); ret_cmd = 1'b1;
        @(negedge core_clk); ret_cmd = 1'b0;
    endtask
    // ********************************
    // Sequence
    // ********************************
    initial begin
        {rst_n, sfr_wr, sfr_bit_wr, sfr_bit_val, sfr_rd, take, ret_cmd} = 7'h00;
        {sfr_addr, sfr_wdata, flg, sfr_bit_sel, spi_flg, ack_wait, ext_flg, ext_en, prio} = 75'h0;
        num_errors = 0;
        n_checks = 0;
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        check("reset_vector", 18'(ive_pkg::RESET_VECTOR), 18'(irq_vector));
        sfr_read(ive_pkg::IE_ADDR, 8'h00, 1'b1);
        sfr_read(8'hB8, 8'h00, 1'b0);
        sfr_write(ive_pkg::IE_ADDR, 8'h5A);
        sfr_write(8'hA9, 8'hFF);
        sfr_read(ive_pkg::IE_ADDR, 8'h5A, 1'b1);
        sfr_bit(3'h7, 1'b1);
        sfr_bit(3'h1, 1'b0);
        sfr_read(ive_pkg::IE_ADDR, 8'hD8, 1'b1);
        // Flag wires: both halves of paired sources, SPI bits 0 and 3, two outside sources
        for (int j = 0; j < 12; j++) begin
            s = j < 4 ? j : (j < 10 ? 4 + (j - 4) / 2 : j + 6);
            sfr_write(ive_pkg::IE_ADDR, 8'h7F);
            ext_en = 11'h7FF;
            raise(j, 1'b1);
            quiet(4);
            sfr_write(ive_pkg::IE_ADDR, 8'h80);
            ext_en = 11'h000;
            quiet(4);
            if (s < 7) sfr_write(ive_pkg::IE_ADDR, 8'h80 | (8'h01 << s));
            else begin @(negedge core_clk); ext_en = 11'h001 << (s - 7); end
            wait_req();
            check("latency", 18'h00001, 18'(n));
            check("vector", 18'(16'h0003 + 16'(8 * s)), 18'(irq_vector));
            take = 1'b1;
            repeat (3) @(negedge core_clk);
            take = 1'b0;
            check("taken", 18'(16'h0003 + 16'(8 * s)), 18'(taken_vec));
            raise(j, 1'b0);
            give_return();
        end
        sfr_write(ive_pkg::IE_ADDR, 8'hFF);
        prio = 18'h00008; flg[1] = 1'b1; flg[3] = 1'b1;
        wait_req();
        check("high_first", 18'h0001B, 18'(irq_vector));
        check("high_level", 18'h00001, 18'(irq_level));
        prio = 18'h00000;
        repeat (2) @(negedge core_clk);
        check("low_order", 18'h0000B, 18'(irq_vector));
        ack_wait = 4'h3; take = 1'b1;
        repeat (8) @(negedge core_clk);
        take = 1'b0; flg[1] = 1'b0;
        check("slow_take", 18'h0000B, 18'(taken_vec));
        quiet(5);
        prio = 18'h00008;
        wait_req();
        check("preempt", 18'h0001B, 18'(irq_vector));
        take = 1'b1;
        repeat (8) @(negedge core_clk);
        take = 1'b0; flg[3] = 1'b0; flg[1] = 1'b1;
        // Low routine still runs after the high one returns, so the low flag must wait
        give_return();
        quiet(3);
        give_return();
        wait_req();
        check("rearm", 18'h0000B, 18'(irq_vector));
        wrap_up();
    end
endmodule // tb_top
`default_nettype wire
